// File: pkg/cpe_pkg.sv
package cpe_pkg;

   // Event-select layout.
   localparam int EVSEL_W         = 16;
   localparam int EVCODE_LSB      = 0;
   localparam int EVCODE_W        = 8;
   localparam int UMASK_LSB       = 8;
   localparam int UMASK_W         = 8;
   localparam int CORE_SPEC_MSB   = 15;
   localparam int CORE_SPEC_LSB   = 14;
   localparam int EVSEL_RESET     = 0;
   localparam int COUNT_RESET     = 0;

   // Event codes.
   localparam logic [7:0] EV_L2_REFUSAL   = 8'h30;
   localparam logic [7:0] EV_L2_IDLE_REQ  = 8'h32;
   localparam logic [7:0] EV_UNHALTED     = 8'h3C;
   localparam logic [7:0] EV_FIRST_LEVEL_PREFETCH_REQUEST_EVENT  = 8'h4F;
   localparam logic [7:0] EV_EXT_SNOOP    = 8'h77;
   localparam logic [7:0] EV_DC_SHARE     = 8'h78;
   localparam logic [7:0] EV_BUS_IDLE     = 8'h7D;
   localparam logic [7:0] EV_BUS_DRDY     = 8'h62;

   // Unit masks, low six bits.
   localparam logic [5:0] UM_CORE_CYC     = 6'h00;
   localparam logic [5:0] UM_REF_CYC      = 6'h01;
   localparam logic [5:0] UM_SERIAL_CYC   = 6'h02;
   localparam logic [5:0] UM_SHARE_SNOOP  = 6'h01;
   localparam logic [5:0] UM_ALL_AGENTS   = 6'h20;

   // Core specificity.
   localparam logic [1:0] SPEC_THIS       = 2'b01;
   localparam logic [1:0] SPEC_ALL        = 2'b11;

   localparam int MAX_INC_W       = 3;

endpackage

// File: verilog/cpe_sync2.sv
`timescale 1ns/1ps
module cpe_sync2 #(
   parameter int W = 1
) (
   input  wire logic         MCLK,
   input  wire logic         RST,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s1_next;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s2_next;

   always_comb begin
      s1_next = d;
      s2_next = s1_reg;
   end

   // Only the second stage is read downstream.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   assign q = s2_reg;
endmodule

// File: verilog/cpe_counter.sv
`timescale 1ns/1ps
// Summary of operation
// - A counter advances only while its core runs code or services a snoop.
// - A halted core being snooped still counts as active.
// - Bits 15:14 of the select pick this core or all cores; 11B means all.
// - Event 3CH cycle counts never advance on a halted core, snooped or not.
// - Bus data-ready event with mask 20H counts all agents' activity.
// - Event 30H counts cycles where the second-level cache refuses requests.
// - Event 32H counts cycles with no requests to the second-level cache.
// - Event 3C mask 00H counts each core clock while active, not halted.
// - Event 3C mask 01H counts each bus clock while the core is not halted.
// - Event 3C mask 02H counts bus clocks running while the other core halts.
// - Event 4FH counts each prefetch request; refused retries count again.
// - Event 78H mask 01H counts data cache snoops for the other core.
// - Event 7DH counts bus cycles with no outstanding transaction of ours.
// - Event 77H counts clean, hit and modified-hit external snoop responses.
// - Counts stall on halt unless snooped, whether core-specific or all-core.
module cpe_counter
   import cpe_pkg::*;
#(
   parameter int COUNT_W = 40
) (
   input  wire logic                 MCLK,
   input  wire logic                 RST,
   input  wire logic [EVSEL_W-1:0]   EVENT_SELECT,
   input  wire logic                 SELECT_WE,
   input  wire logic                 COUNT_CLEAR,
   input  wire logic                 CORE_HALTED,
   input  wire logic                 CORE_SNOOPED,
   input  wire logic                 OTHER_HALTED,
   input  wire logic                 OTHER_SNOOPED,
   input  wire logic                 BUS_CLK_TICK,
   input  wire logic                 L2_REFUSE,
   input  wire logic                 L2_REQ_ANY,
   input  wire logic                 FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS,
   input  wire logic                 FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER,
   input  wire logic                 DC_SHARE_SNOOP,
   input  wire logic                 BUS_PENDING,
   input  wire logic [1:0]           EXT_SNOOP_RESP,
   input  wire logic                 BUS_DRDY_THIS,
   input  wire logic                 BUS_DRDY_ANY,
   output logic      [COUNT_W-1:0]   COUNT,
   output logic      [EVSEL_W-1:0]   SELECT_READBACK,
   output logic                      CORE_ACTIVE
);

   // Refused at elaboration: below 8 bits a busy event wraps within a few cycles,
   // and above 64 bits the readback path has no room.
   if (COUNT_W < 8 || COUNT_W > 64) begin : g_bad_count_w
      $error("COUNT_W must lie between 8 and 64");
   end
   // The increment must hold two strobes in one cycle.
   if (MAX_INC_W < 2) begin : g_bad_inc_w
      $error("MAX_INC_W must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////
   // The bus tick and snoop response cross from another domain; synchronise them first.
   // The response code is only told apart from none, so a skew between its two bits can at worst
   // lose one cycle when one response follows another with no idle code between them.

   logic [2:0] bus_raw;
   logic [2:0] bus_sync;
   assign bus_raw = {BUS_CLK_TICK, EXT_SNOOP_RESP};

   cpe_sync2 #(
      .W (3)
   ) u_sync (
      .MCLK (MCLK),
      .RST  (RST),
      .d    (bus_raw),
      .q    (bus_sync)
   );

   function automatic logic [MAX_INC_W-1:0] add2(input logic a, input logic b);
      add2 = MAX_INC_W'({1'b0, a} + {1'b0, b});
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Event selection and increment.

   logic [EVSEL_W-1:0]   evsel_reg;
   logic [EVSEL_W-1:0]   evsel_next;
   logic [COUNT_W-1:0]   count_reg;
   logic [COUNT_W-1:0]   count_next;
   logic                 active_reg;
   logic                 active_next;
   logic [EVCODE_W-1:0]  code;
   logic [5:0]           um;
   logic [1:0]           spec;
   logic                 all_cores;
   logic                 all_agents;
   logic                 active;
   logic                 running;
   logic                 bus_tick;
   logic                 snoop_resp;
   logic [MAX_INC_W-1:0] inc;

   assign code       = evsel_reg[EVCODE_LSB +: EVCODE_W];
   assign um         = evsel_reg[UMASK_LSB +: CORE_SPEC_LSB - UMASK_LSB];
   assign spec       = evsel_reg[CORE_SPEC_MSB:CORE_SPEC_LSB];
   assign all_cores  = (spec == SPEC_ALL);
   assign running    = !CORE_HALTED;
   assign active     = running || CORE_SNOOPED;
   // The other core's snoop state qualifies no event here; it stays at the pins for events to come.
   assign all_agents = (um == UM_ALL_AGENTS) || all_cores;
   assign bus_tick   = bus_sync[2];
   // Only a response code other than none is counted.
   assign snoop_resp = (bus_sync[1:0] != 2'b00);

   always_comb begin
      inc = '0;
      if (code == EV_UNHALTED) begin
         // Snoops do not wake these cycle counts.
         if (um == UM_CORE_CYC) begin
            inc = add2(running, 1'b0);
         end else if (um == UM_REF_CYC) begin
            inc = add2(running && bus_tick, 1'b0);
         end else if (um == UM_SERIAL_CYC) begin
            inc = add2(running && OTHER_HALTED && bus_tick, 1'b0);
         end
      end else if (code == EV_L2_REFUSAL) begin
         inc = add2(L2_REFUSE, 1'b0);
      end else if (code == EV_L2_IDLE_REQ) begin
         inc = add2(!L2_REQ_ANY, 1'b0);
      end else if (code == EV_FIRST_LEVEL_PREFETCH_REQUEST_EVENT) begin
         // A retried request shows again on the strobe and is counted again.
         if (all_cores) begin
            inc = add2(FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS, FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER);
         end else begin
            inc = add2(FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS, 1'b0);
         end
      end else if (code == EV_DC_SHARE) begin
         if (um == UM_SHARE_SNOOP) begin
            inc = add2(DC_SHARE_SNOOP, 1'b0);
         end
      end else if (code == EV_BUS_IDLE) begin
         inc = add2(bus_tick && !BUS_PENDING, 1'b0);
      end else if (code == EV_EXT_SNOOP) begin
         inc = add2(snoop_resp, 1'b0);
      end else if (code == EV_BUS_DRDY) begin
         if (all_agents) begin
            inc = add2(BUS_DRDY_ANY, 1'b0);
         end else begin
            inc = add2(BUS_DRDY_THIS, 1'b0);
         end
      end
   end

   always_comb begin
      evsel_next  = SELECT_WE ? EVENT_SELECT : evsel_reg;
      active_next = active;
      count_next  = count_reg;
      // Clear wins over a same-cycle increment, so a count read right after a clear is zero.
      if (COUNT_CLEAR) begin
         count_next = '0;
      end else if (active) begin
         // Unmatched codes give zero increment.
         count_next = count_reg + COUNT_W'(inc);
      end
   end

   always_ff @(posedge MCLK) begin
      // Reset leaves the select at a code that matches no event, so nothing counts until it is loaded.
      if (RST) begin
         evsel_reg  <= EVSEL_W'(EVSEL_RESET);
         count_reg  <= COUNT_W'(COUNT_RESET);
         active_reg <= 1'b0;
      end else begin
         evsel_reg  <= evsel_next;
         count_reg  <= count_next;
         active_reg <= active_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   // The count wraps silently at full scale, so software must read it often enough to see each wrap.
   // The active flag shows the qualifier one cycle late, as it is registered like every output.

   assign COUNT           = count_reg;
   assign SELECT_READBACK = evsel_reg;
   assign CORE_ACTIVE     = active_reg;

endmodule

// File: verif/cpe_counter_properties.sv
`timescale 1ns/1ps
module cpe_counter_properties
   import cpe_pkg::*;
#(
   parameter int COUNT_W = 40
) (
   input wire logic               MCLK,
   input wire logic               RST,
   input wire logic [EVSEL_W-1:0] EVENT_SELECT,
   input wire logic               SELECT_WE,
   input wire logic               COUNT_CLEAR,
   input wire logic               CORE_HALTED,
   input wire logic               CORE_SNOOPED,
   input wire logic               L2_REFUSE,
   input wire logic               FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS,
   input wire logic               FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER,
   input wire logic [COUNT_W-1:0] COUNT,
   input wire logic [EVSEL_W-1:0] SELECT_READBACK,
   input wire logic               CORE_ACTIVE
);
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (RST);
   // Clear is excluded because it wins over any increment.
   wire run = !CORE_HALTED && !COUNT_CLEAR;
   a_select_load: assert property (SELECT_WE |=> SELECT_READBACK == $past(EVENT_SELECT)) else $error("select");
   a_clear_zero: assert property (COUNT_CLEAR |=> COUNT == '0) else $error("clear");
   a_halt_freeze: assert property (CORE_HALTED && !CORE_SNOOPED && !COUNT_CLEAR |=> $stable(COUNT))
      else $error("halted count");
   a_unhalted_hold: assert property (CORE_HALTED && !COUNT_CLEAR && SELECT_READBACK[7:0] == EV_UNHALTED
      |=> $stable(COUNT)) else $error("unhalted count");
   a_core_cycle: assert property (run && SELECT_READBACK == 16'h403C |=> COUNT == $past(COUNT) + 1'b1)
      else $error("core cycle");
   a_refuse_add: assert property (run && SELECT_READBACK == 16'h4030
      |=> COUNT == $past(COUNT) + $past(L2_REFUSE)) else $error("refusal");
   a_pref_pair: assert property (run && SELECT_READBACK == 16'hC04F
      |=> COUNT == $past(COUNT) + $past(FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS) + $past(FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER)) else $error("prefetch");
   a_snoop_active: assert property (CORE_HALTED && CORE_SNOOPED |=> CORE_ACTIVE) else $error("active");
   c_pair: cover property (SELECT_READBACK == 16'hC04F && FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS && FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER && run);
   c_snooped: cover property (CORE_HALTED && CORE_SNOOPED);
   c_clear: cover property (COUNT_CLEAR && COUNT != '0);
endmodule
bind cpe_counter cpe_counter_properties #(.COUNT_W(COUNT_W)) i_props (.MCLK, .RST, .EVENT_SELECT, .SELECT_WE,
   .COUNT_CLEAR, .CORE_HALTED, .CORE_SNOOPED, .L2_REFUSE, .FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS, .FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER, .COUNT,
   .SELECT_READBACK, .CORE_ACTIVE);

// File: verif/cpe_agents_model.sv
`timescale 1ns/1ps
module cpe_agents_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       hold,
   input  wire logic       oth_halt,
   output logic            tick,
   output logic      [1:0] resp,
   output logic            other_halted,
   output logic            other_snooped
);
   logic [1:0] kind_reg = 2'h1;
   // Kinds rotate on the falling edge so the response never moves at the sampling edge.
   always @(negedge clk) begin
      kind_reg <= (kind_reg == 2'h3) ? 2'h1 : kind_reg + 2'h1;
   end
   assign tick = go | hold;
   assign resp = go ? kind_reg : 2'h0;
   assign other_halted = oth_halt;
   assign other_snooped = 1'b0;
endmodule

// File: verif/cpe_counter_tb.sv
`timescale 1ns/1ps
module cpe_counter_tb;
   logic        MCLK = 0, RST = 1, SELECT_WE = 0, COUNT_CLEAR = 0, go = 0, BUS_CLK_TICK, OTHER_HALTED, OTHER_SNOOPED;
   logic [15:0] EVENT_SELECT = '0, lfsr = 16'h6A8C;
   logic [15:0] readback, qs[$];
   logic        core_active, qa[$];
   logic [11:0] v = 12'h044;
   logic [39:0] COUNT, q[$];
   logic [1:0]  EXT_SNOOP_RESP;
   int          failures = 0, n_tests = 0;
   event        chk;
   cpe_counter i_dut (.MCLK, .RST, .EVENT_SELECT, .SELECT_WE, .COUNT_CLEAR, .CORE_HALTED(v[9]), .CORE_SNOOPED(v[8]),
      .OTHER_HALTED, .OTHER_SNOOPED, .BUS_CLK_TICK, .L2_REFUSE(v[7]), .L2_REQ_ANY(v[6]), .FIRST_LEVEL_PREFETCH_REQUEST_EVENT_THIS(v[5]),
      .FIRST_LEVEL_PREFETCH_REQUEST_EVENT_OTHER(v[4]), .DC_SHARE_SNOOP(v[3]), .BUS_PENDING(v[2]), .EXT_SNOOP_RESP, .BUS_DRDY_THIS(v[1]),
      .BUS_DRDY_ANY(v[0]), .COUNT, .SELECT_READBACK(readback), .CORE_ACTIVE(core_active));
   cpe_agents_model i_agents (.clk(MCLK), .go, .hold(v[10]), .oth_halt(v[11]), .tick(BUS_CLK_TICK),
      .resp(EXT_SNOOP_RESP), .other_halted(OTHER_HALTED), .other_snooped(OTHER_SNOOPED));
   ////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 MCLK = ~MCLK;
   end
   task automatic cyc();
      @(posedge MCLK);
      #1;
   endtask
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Totals are compared after a quiet tail, so the two-stage sync delay cannot shift the sum.
   task automatic scen(input logic [15:0] sel, input logic [11:0] act, input logic [11:0] idl, input int per);
      int ones;
      ones = 0;
      cyc();
      v = idl;
      EVENT_SELECT = sel;
      SELECT_WE = 1;
      COUNT_CLEAR = 1;
      cyc();
      SELECT_WE = 0;
      COUNT_CLEAR = 0;
      repeat (20) begin
         cyc();
         lfsr = lfsr_step(lfsr);
         go = lfsr[0];
         v = go ? act : idl;
         ones += go;
      end
      cyc();
      go = 0;
      v = idl;
      repeat (5) cyc();
      q.push_back(40'(ones * per));
      qs.push_back(sel);
      qa.push_back(!idl[9] || idl[8]);
      ->chk;
   endtask
   initial begin
      forever begin
         @chk;
         check(COUNT, q.pop_front());
         check(40'(readback), 40'(qs.pop_front()));
         check(40'(core_active), 40'(qa.pop_front()));
      end
   end
   initial begin
      repeat (3) cyc();
      RST = 0;
      scen(16'h4030, 12'h0C4, 12'h044, 1);
      scen(16'h4030, 12'h2C4, 12'h244, 0);
      scen(16'h4030, 12'h3C4, 12'h344, 1);
      scen(16'h4032, 12'h004, 12'h044, 1);
      scen(16'h403C, 12'h044, 12'h244, 1);
      scen(16'h403C, 12'h344, 12'h344, 0);
      scen(16'h413C, 12'h044, 12'h044, 1);
      scen(16'h423C, 12'h844, 12'h844, 1);
      scen(16'h423C, 12'h044, 12'h044, 0);
      scen(16'hC04F, 12'h074, 12'h044, 2);
      scen(16'h404F, 12'h074, 12'h044, 1);
      scen(16'h4178, 12'h04C, 12'h044, 1);
      scen(16'h4278, 12'h04C, 12'h044, 0);
      scen(16'h407D, 12'h440, 12'h444, 1);
      scen(16'h4077, 12'h044, 12'h044, 1);
      scen(16'h6062, 12'h045, 12'h044, 1);
      cyc();
      end_sim();
   end
endmodule
